/* design/nibble_io_ports.sv */
// How it works
// - nibble read returns all four synchronised pin levels of chosen group
// - bit test returns one pin level for branch on one or zero
// - set or clear changes one output latch bit, others untouched
// - per pin fixed option chooses open drain or open drain with pull-up
// - reset sets all latches high so transistors are off
// - port A pin levels go also to converter channels 0 to 3
// - port A bit 3 feeds external interrupt request 1
// - port B behaves like A and feeds converter channels 4 to 7
// - port B bit 0 may carry the narrow pwm output
// - port B bit 1 may carry the wide pwm output
// - port B bit 2 may carry the square wave output
// - port B bit 3 passes standby control input to standby logic
module nibble_io_ports #(
	parameter logic [3:0] PULLUP_A = nibble_io_pkg::PULLUP_OPTION_DEFAULT,
	parameter logic [3:0] PULLUP_B = nibble_io_pkg::PULLUP_OPTION_DEFAULT
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// core requests
	input wire nibble_io_pkg::core_req_type req_i,
	input wire logic read_sel_i,
	input wire logic [1:0] test_bit_i,
	// core answers
	output logic [3:0] read_nibble_o,
	output logic test_level_o,
	// shared functions
	input wire nibble_io_pkg::alt_out_type alt_i,
	output logic [7:0] analog_channel_input_o,
	output logic ext_irq_1_o,
	output logic standby_start_o,
	// port A pins
	input wire logic [3:0] port_a_pins_i,
	output logic [3:0] port_a_pins_o,
	output logic [3:0] port_a_pins_oe_o,
	output logic [3:0] port_a_pullup_o,
	// port B pins
	input wire logic [3:0] port_b_pins_i,
	output logic [3:0] port_b_pins_o,
	output logic [3:0] port_b_pins_oe_o,
	output logic [3:0] port_b_pullup_o
);
	logic [3:0] latch_a_reg;
	logic [3:0] latch_b_reg;
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] drive_b_next;
	logic [3:0] sel_levels;

	// drive low when the effective output bit is zero
	function automatic logic [3:0] low_drive(input logic [3:0] value);
		low_drive = ~value;
	endfunction : low_drive

	function automatic logic [3:0] apply_op(input logic [3:0] cur,
		input logic [1:0] bsel, input nibble_io_pkg::bit_op_type op);
		logic [3:0] res;
		res = cur;
		unique case (op)
			nibble_io_pkg::OP_SET_BIT: res[bsel] = 1'b1;
			nibble_io_pkg::OP_CLEAR_BIT: res[bsel] = 1'b0;
			nibble_io_pkg::OP_NONE: res = cur;
			default: res = cur;
		endcase
		apply_op = res;
	endfunction : apply_op

	// both core answers pick the same group, so one decoder serves them
	function automatic logic [3:0] group_levels(input logic sel, input logic [3:0] lvl_a,
		input logic [3:0] lvl_b);
		group_levels = (sel == nibble_io_pkg::PORT_SEL_B) ? lvl_b : lvl_a;
	endfunction : group_levels

	// which alternate function, if any, owns a port B pin
	function automatic logic alt_enable(input nibble_io_pkg::alt_out_type alt, input int idx);
		alt_enable = 1'b0;
		if (idx == nibble_io_pkg::PWM_NARROW_BIT) begin
			alt_enable = alt.pwm_narrow_en;
		end else if (idx == nibble_io_pkg::PWM_WIDE_BIT) begin
			alt_enable = alt.pwm_wide_en;
		end else if (idx == nibble_io_pkg::SQUARE_BIT) begin
			alt_enable = alt.square_en;
		end
	endfunction : alt_enable

	// level an alternate function puts on its pin; released high otherwise
	function automatic logic alt_level(input nibble_io_pkg::alt_out_type alt, input int idx);
		alt_level = 1'b1;
		if (idx == nibble_io_pkg::PWM_NARROW_BIT) begin
			alt_level = alt.pwm_narrow_out;
		end else if (idx == nibble_io_pkg::PWM_WIDE_BIT) begin
			alt_level = alt.pwm_wide_out;
		end else if (idx == nibble_io_pkg::SQUARE_BIT) begin
			alt_level = alt.square_wave_out;
		end
	endfunction : alt_level

	// one shared synchroniser; it idles high in reset like the released pins
	pin_sync #(
		.WIDTH(8)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i({port_b_pins_i, port_a_pins_i}),
		.sync_o({sync_b, sync_a})
	);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			latch_a_reg <= nibble_io_pkg::LATCH_RESET;
		end else if (req_i.port_sel == nibble_io_pkg::PORT_SEL_A) begin
			latch_a_reg <= apply_op(latch_a_reg, req_i.bit_sel, req_i.op);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			latch_b_reg <= nibble_io_pkg::LATCH_RESET;
		end else if (req_i.port_sel == nibble_io_pkg::PORT_SEL_B) begin
			latch_b_reg <= apply_op(latch_b_reg, req_i.bit_sel, req_i.op);
		end
	end

	// alternate source wins over the latch while enabled
	for (genvar pin = 0; pin < 4; pin++) begin : g_drive_b
		assign drive_b_next[pin] = alt_enable(alt_i, pin) ? alt_level(alt_i, pin) :
			latch_b_reg[pin];
	end

	// open drain: the pin only ever pulls low, so data is always zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			port_a_pins_o <= '0;
			port_b_pins_o <= '0;
		end else begin
			port_a_pins_o <= '0;
			port_b_pins_o <= '0;
		end
	end

	// a latch at one leaves the transistor off
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			port_a_pins_oe_o <= '0;
		end else begin
			port_a_pins_oe_o <= low_drive(latch_a_reg);
		end
	end

	// port B enables, after the alternate override
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			port_b_pins_oe_o <= '0;
		end else begin
			port_b_pins_oe_o <= low_drive(drive_b_next);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			port_a_pullup_o <= PULLUP_A;
		end else begin
			port_a_pullup_o <= PULLUP_A;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			port_b_pullup_o <= PULLUP_B;
		end else begin
			port_b_pullup_o <= PULLUP_B;
		end
	end

	assign sel_levels = group_levels(read_sel_i, sync_a, sync_b);

	// nibble answer, one cycle after the request
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			read_nibble_o <= nibble_io_pkg::LATCH_RESET;
		end else begin
			read_nibble_o <= sel_levels;
		end
	end

	// single level for branch on one or zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			test_level_o <= &nibble_io_pkg::LATCH_RESET;
		end else begin
			test_level_o <= sel_levels[test_bit_i];
		end
	end

	// converter sees digital levels only, channels 0 to 7
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			analog_channel_input_o <= {nibble_io_pkg::LATCH_RESET,
				nibble_io_pkg::LATCH_RESET};
		end else begin
			analog_channel_input_o <= {sync_b, sync_a};
		end
	end

	// interrupt request follows port A bit 3
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_irq_1_o <= nibble_io_pkg::LATCH_RESET[nibble_io_pkg::IRQ_BIT];
		end else begin
			ext_irq_1_o <= sync_a[nibble_io_pkg::IRQ_BIT];
		end
	end

	// standby input, no filter beyond the synchroniser
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			standby_start_o <= nibble_io_pkg::LATCH_RESET[nibble_io_pkg::STANDBY_BIT];
		end else begin
			standby_start_o <= sync_b[nibble_io_pkg::STANDBY_BIT];
		end
	end
endmodule : nibble_io_ports

/* include/nibble_io_pkg.sv */
package nibble_io_pkg;
	localparam int PORT_WIDTH = 4;
	localparam logic [3:0] LATCH_RESET = 4'hF;
	localparam logic [3:0] PULLUP_OPTION_DEFAULT = 4'h0;
	localparam int IRQ_BIT = 3;
	localparam int PWM_NARROW_BIT = 0;
	localparam int PWM_WIDE_BIT = 1;
	localparam int SQUARE_BIT = 2;
	localparam int STANDBY_BIT = 3;
	localparam logic PORT_SEL_A = 1'b0;
	localparam logic PORT_SEL_B = 1'b1;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_SET_BIT,
		OP_CLEAR_BIT
	} bit_op_type;

	typedef struct packed {
		logic port_sel;
		logic [1:0] bit_sel;
		bit_op_type op;
	} core_req_type;

	typedef struct packed {
		logic pwm_narrow_en;
		logic pwm_narrow_out;
		logic pwm_wide_en;
		logic pwm_wide_out;
		logic square_en;
		logic square_wave_out;
	} alt_out_type;
endpackage : nibble_io_pkg

/* design/pin_sync.sv */
module pin_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// raw and synchronised levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1_reg;

	// reset to high: pins idle high with transistors off
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			stage1_reg <= '1;
			sync_o <= '1;
		end else begin
			stage1_reg <= async_i;
			sync_o <= stage1_reg;
		end
	end
endmodule : pin_sync

/* tb/nibble_io_ports_chk.sv */
module nibble_io_ports_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire nibble_io_pkg::core_req_type req_i,
	input wire logic read_sel_i,
	input wire nibble_io_pkg::alt_out_type alt_i,
	input wire logic [3:0] read_nibble_o,
	input wire logic [7:0] analog_channel_input_o,
	input wire logic ext_irq_1_o,
	input wire logic standby_start_o,
	input wire logic [3:0] port_a_pins_i,
	input wire logic [3:0] port_b_pins_i,
	input wire logic [3:0] port_a_pins_o,
	input wire logic [3:0] port_b_pins_o,
	input wire logic [3:0] port_a_pins_oe_o,
	input wire logic [3:0] port_b_pins_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] up_reg;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// skip the cycles in which the sync chain still holds reset levels
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) up_reg <= 2'h0;
		else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
	end
	rst_off_a: assert property ($fell(rst_i) |-> !(port_a_pins_oe_o | port_b_pins_oe_o))
		else $error("pin pulled low right after reset");
	irq_lag_a: assert property (up_reg == 2'h3 |->
		ext_irq_1_o == $past(port_a_pins_i[3], 3))
		else $error("interrupt request does not follow port A bit 3");
	stby_lag_a: assert property (up_reg == 2'h3 |->
		standby_start_o == $past(port_b_pins_i[3], 3))
		else $error("standby input does not follow port B bit 3");
	chan_map_a: assert property (up_reg == 2'h3 |->
		analog_channel_input_o == $past({port_b_pins_i, port_a_pins_i}, 3))
		else $error("converter channel level mismatch");
	read_nib_a: assert property (up_reg == 2'h3 |-> read_nibble_o ==
		($past(read_sel_i) ? $past(port_b_pins_i, 3) : $past(port_a_pins_i, 3)))
		else $error("nibble read mismatch");
	clr_bit_a: assert property ((req_i.op == nibble_io_pkg::OP_CLEAR_BIT && !req_i.port_sel)
		##2 1 |-> port_a_pins_oe_o[$past(req_i.bit_sel, 2)])
		else $error("cleared latch bit not driving low");
	pwm_pin_a: assert property (alt_i.pwm_narrow_en |=>
		port_b_pins_oe_o[0] == !$past(alt_i.pwm_narrow_out))
		else $error("narrow pwm level not on pin");
	wide_pin_a: assert property (alt_i.pwm_wide_en |=>
		port_b_pins_oe_o[1] == !$past(alt_i.pwm_wide_out))
		else $error("wide pwm level not on pin");
	sq_pin_a: assert property (alt_i.square_en |=>
		port_b_pins_oe_o[2] == !$past(alt_i.square_wave_out))
		else $error("square wave level not on pin");
	drain_low_a: assert property ((port_a_pins_o | port_b_pins_o) == 4'h0)
		else $error("open drain data line not low");
	cover property (req_i.op == nibble_io_pkg::OP_SET_BIT);
	cover property (req_i.op == nibble_io_pkg::OP_CLEAR_BIT && req_i.port_sel);
	cover property (alt_i.square_en);
	cover property (read_sel_i);
endmodule : nibble_io_ports_chk
bind nibble_io_ports nibble_io_ports_chk nibble_io_ports_chk_inst (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.req_i(req_i),
	.read_sel_i(read_sel_i),
	.alt_i(alt_i),
	.read_nibble_o(read_nibble_o),
	.analog_channel_input_o(analog_channel_input_o),
	.ext_irq_1_o(ext_irq_1_o),
	.standby_start_o(standby_start_o),
	.port_a_pins_i(port_a_pins_i),
	.port_b_pins_i(port_b_pins_i),
	.port_a_pins_o(port_a_pins_o),
	.port_b_pins_o(port_b_pins_o),
	.port_a_pins_oe_o(port_a_pins_oe_o),
	.port_b_pins_oe_o(port_b_pins_oe_o)
);

/* tb/board_model.sv */
module board_model (
	input wire logic [7:0] oe_i,
	input wire logic [7:0] drive_i,
	output logic [7:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pins_o = drive_i & ~oe_i;
endmodule : board_model

/* tb/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic read_sel_i = 1'b0;
	logic [1:0] test_bit_i = 2'h0;
	nibble_io_pkg::core_req_type req_i = '0;
	nibble_io_pkg::alt_out_type alt_i = '0;
	logic [7:0] drive = 8'hFF;
	logic [7:0] pins;
	logic [3:0] nib;
	logic lvl;
	logic [3:0] a_oe;
	logic [3:0] b_oe;
	logic [3:0] a_pu;
	logic [3:0] b_pu;
	localparam logic [3:0] PULLUP_A_OPT = 4'h3;
	localparam logic [3:0] PULLUP_B_OPT = 4'hC;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	initial forever #50 ref_clk_i = ~ref_clk_i;
	board_model board_model_inst (.oe_i({b_oe, a_oe}), .drive_i(drive), .pins_o(pins));
	nibble_io_ports #(.PULLUP_A(PULLUP_A_OPT), .PULLUP_B(PULLUP_B_OPT)) nibble_io_ports_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
		.read_sel_i(read_sel_i), .test_bit_i(test_bit_i), .read_nibble_o(nib),
		.test_level_o(lvl), .alt_i(alt_i), .analog_channel_input_o(), .ext_irq_1_o(),
		.standby_start_o(), .port_a_pins_i(pins[3:0]), .port_a_pins_o(),
		.port_a_pins_oe_o(a_oe), .port_a_pullup_o(a_pu), .port_b_pins_i(pins[7:4]),
		.port_b_pins_o(), .port_b_pins_oe_o(b_oe), .port_b_pullup_o(b_pu));
	task end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %h %h", $time, got, exp);
		end
	endtask : chk
	task wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : wait_n
	task issue(input logic p, input logic [1:0] b, input nibble_io_pkg::bit_op_type o);
		@(posedge ref_clk_i);
		req_i <= '{p, b, o};
	endtask : issue
	task t_read();
		@(posedge ref_clk_i);
		drive <= 8'hA5;
		wait_n(4);
		chk({4'h0, nib}, 8'h05);
		@(posedge ref_clk_i);
		read_sel_i <= 1'b1;
		wait_n(2);
		chk({4'h0, nib}, 8'h0A);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			test_bit_i <= i[1:0];
			wait_n(2);
			chk({7'h0, lvl}, {7'h0, i[0]});
		end
		@(posedge ref_clk_i);
		drive <= 8'hFF;
		read_sel_i <= 1'b0;
	endtask : t_read
	task t_latch();
		issue(nibble_io_pkg::PORT_SEL_A, 2'h1, nibble_io_pkg::OP_CLEAR_BIT);
		issue(nibble_io_pkg::PORT_SEL_A, 2'h1, nibble_io_pkg::OP_NONE);
		wait_n(2);
		chk({b_oe, a_oe}, 8'h02);
		issue(nibble_io_pkg::PORT_SEL_B, 2'h3, nibble_io_pkg::OP_CLEAR_BIT);
		issue(nibble_io_pkg::PORT_SEL_A, 2'h1, nibble_io_pkg::OP_SET_BIT);
		issue(nibble_io_pkg::PORT_SEL_A, 2'h1, nibble_io_pkg::OP_NONE);
		wait_n(2);
		chk({b_oe, a_oe}, 8'h80);
		issue(nibble_io_pkg::PORT_SEL_B, 2'h3, nibble_io_pkg::OP_SET_BIT);
		issue(nibble_io_pkg::PORT_SEL_B, 2'h3, nibble_io_pkg::OP_NONE);
	endtask : t_latch
	task t_alt();
		@(posedge ref_clk_i);
		alt_i <= 6'b101010;
		wait_n(2);
		chk({4'h0, b_oe}, 8'h07);
		@(posedge ref_clk_i);
		alt_i <= 6'b111111;
		wait_n(2);
		chk({4'h0, b_oe}, 8'h00);
	endtask : t_alt
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 500) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		wait_n(1);
		chk({b_oe, a_oe}, 8'h00);
		chk({4'h0, nib}, 8'h0F);
		chk({b_pu, a_pu}, {PULLUP_B_OPT, PULLUP_A_OPT});
		t_read();
		t_latch();
		t_alt();
		end_sim();
	end
endmodule : tb
